// ### core/ccmri_dma.sv
// single-word memory access engine toward data ram
`timescale 1ns/1ps
module ccmri_dma (
    input wire logic ref_clk,
    input wire logic rst_n,
    ccmri_mem_if.eng mem,
    output logic ram_req,
    output logic ram_wr,
    output logic [31:0] ram_addr,
    output logic [31:0] ram_wdata,
    input wire logic ram_gnt,
    input wire logic [31:0] ram_rdata,
    input wire logic ram_busy
);
    logic busy_q, busy_d;
    logic ack_q, ack_d;
    logic coll_q, coll_d;
    logic [31:0] rdata_q, rdata_d;

    // issue one access, register the returned word
    always_comb begin
        busy_d = busy_q;
        ack_d = 1'b0;
        coll_d = 1'b0;
        rdata_d = rdata_q;
        if (mem.req && !busy_q && !ack_q) begin
            busy_d = 1'b1;
        end else if (busy_q && ram_gnt) begin
            busy_d = 1'b0;
            ack_d = 1'b1;
            rdata_d = ram_rdata;
        end
        if (busy_q && ram_busy) begin
            coll_d = 1'b1; // contention while holding a request
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            coll_q <= 1'b0;
            rdata_q <= ccmri_pkg::RESET_ZERO;
        end else begin
            busy_q <= busy_d;
            ack_q <= ack_d;
            coll_q <= coll_d;
            rdata_q <= rdata_d;
        end
    end

    assign ram_req = busy_q;
    assign ram_wr = mem.wr;
    assign ram_addr = mem.addr;
    assign ram_wdata = mem.wdata;
    assign mem.ack = ack_q;
    assign mem.rdata = rdata_q;
    assign mem.collision = coll_q;
endmodule : ccmri_dma

// ### core/ccmri_top.sv
// task, event and configuration registers of the ccm packet cipher
// How it works
// - writing one at 0x000 starts keystream generation that ends alone.
// - writing one at 0x004 starts the cipher pass that ends alone.
// - writing one at 0x008 stops a running cipher pass.
// - the swap task at 0x00C copies the alternate rate into the mode.
// - a link register at 0x200 joins own events to own tasks.
// - key and nonce are fetched from the structure at the 0x508 pointer.
// - working storage sits at the 0x514 pointer.
// - extended length mode takes keystream length from 0x518.
// - the block lives at base 0x4000F000 with offsets relative to it.
// - with the link on, keystream done starts the cipher pass.
// - memory access ceases once cipher done is raised, or keystream done with the link off.
// - memory contention during a cipher pass raises the fault event.
// - writing one to an enable-set bit enables that interrupt.
`timescale 1ns/1ps
module ccmri_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    output logic irq,
    output logic ram_req,
    output logic ram_wr,
    output logic [31:0] ram_addr,
    output logic [31:0] ram_wdata,
    input wire logic ram_gnt,
    input wire logic [31:0] ram_rdata,
    input wire logic ram_busy,
    input wire logic [7:0] cipher_len,
    input wire logic mic_ok
);
    ccmri_mem_if mem ();

    // register decoding shared by read and write paths
    function automatic logic hit(input logic [31:0] a, input logic [11:0] o);
        return a == (ccmri_pkg::CCMRI_BASE_ADDR | {20'h0_0000, o});
    endfunction : hit

    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    logic [2:0] ev_q, ev_d; // bit0 keystream, bit1 cipher, bit2 fault
    logic [2:0] ien_q, ien_d;
    logic link_q, link_d;
    logic [1:0] enable_q, enable_d;
    logic [31:0] mode_q, mode_d;
    logic [31:0] cnf_q, cnf_d, src_q, src_d, dst_q, dst_d;
    logic [31:0] tmp_q, tmp_d, ext_q, ext_d, alt_q, alt_d, hdr_q, hdr_d;
    logic mic_q, mic_d;
    logic wr_acc, rd_acc;
    logic go_ks, go_cipher, go_halt, go_swap;
    logic ks_done, cipher_done, fault;
    logic [31:0] wmask;

    // writes land at the edge where waitrequest is seen low
    assign wr_acc = avs_write && ack_q;
    assign rd_acc = avs_read && !ack_q;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign go_ks = wr_acc && hit(avs_address, ccmri_pkg::OFS_TASK_KS)
        && avs_writedata[0];
    assign go_cipher = wr_acc && hit(avs_address, ccmri_pkg::OFS_TASK_CIPHER)
        && avs_writedata[0];
    assign go_halt = wr_acc && hit(avs_address, ccmri_pkg::OFS_TASK_HALT)
        && avs_writedata[0];
    assign go_swap = wr_acc && hit(avs_address, ccmri_pkg::OFS_TASK_SWAP)
        && avs_writedata[0];

    // register writes, sticky events and task side effects
    always_comb begin
        ack_d = avs_read || avs_write ? !ack_q : 1'b0;
        resp_d = 2'b00;
        rdata_d = ccmri_pkg::UNMAPPED_READ;
        ev_d = ev_q;
        ien_d = ien_q;
        link_d = link_q;
        enable_d = enable_q;
        mode_d = mode_q;
        cnf_d = cnf_q;
        src_d = src_q;
        dst_d = dst_q;
        tmp_d = tmp_q;
        ext_d = ext_q;
        alt_d = alt_q;
        hdr_d = hdr_q;
        mic_d = mic_q;
        if (wr_acc) begin
            if (hit(avs_address, ccmri_pkg::OFS_EV_KS)) begin
                ev_d[0] = avs_writedata[0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_EV_CIPHER)) begin
                ev_d[1] = avs_writedata[0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_EV_FAULT)) begin
                ev_d[2] = avs_writedata[0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_LINKS)) begin
                link_d = avs_writedata[0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_IRQ_SET)) begin
                ien_d = ien_q | avs_writedata[2:0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_IRQ_CLR)) begin
                ien_d = ien_q & ~avs_writedata[2:0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_ENABLE)) begin
                enable_d = avs_writedata[1:0];
            end
            if (hit(avs_address, ccmri_pkg::OFS_MODE)) begin
                mode_d = (mode_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_CNF_PTR)) begin
                cnf_d = (cnf_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_SRC_PTR)) begin
                src_d = (src_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_DST_PTR)) begin
                dst_d = (dst_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_TMP_PTR)) begin
                tmp_d = (tmp_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_EXT_LEN)) begin
                ext_d = (ext_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_ALT_RATE)) begin
                alt_d = (alt_q & ~wmask) | (avs_writedata & wmask);
            end
            if (hit(avs_address, ccmri_pkg::OFS_HDR_MASK)) begin
                hdr_d = (hdr_q & ~wmask) | (avs_writedata & wmask);
            end
        end
        if (go_swap) begin
            mode_d[ccmri_pkg::MODE_RATE_LSB +: 8] = alt_q[7:0];
        end
        // hardware set wins over software clear
        if (ks_done) ev_d[0] = 1'b1;
        if (cipher_done) begin
            ev_d[1] = 1'b1;
            mic_d = mic_ok;
        end
        if (fault) ev_d[2] = 1'b1;
        if (rd_acc) begin
            unique case (1'b1)
                hit(avs_address, ccmri_pkg::OFS_EV_KS):
                    rdata_d = {31'h0, ev_q[0]};
                hit(avs_address, ccmri_pkg::OFS_EV_CIPHER):
                    rdata_d = {31'h0, ev_q[1]};
                hit(avs_address, ccmri_pkg::OFS_EV_FAULT):
                    rdata_d = {31'h0, ev_q[2]};
                hit(avs_address, ccmri_pkg::OFS_LINKS):
                    rdata_d = {31'h0, link_q};
                hit(avs_address, ccmri_pkg::OFS_IRQ_SET),
                hit(avs_address, ccmri_pkg::OFS_IRQ_CLR):
                    rdata_d = {29'h0, ien_q};
                hit(avs_address, ccmri_pkg::OFS_MIC): rdata_d = {31'h0, mic_q};
                hit(avs_address, ccmri_pkg::OFS_ENABLE):
                    rdata_d = {30'h0, enable_q};
                hit(avs_address, ccmri_pkg::OFS_MODE): rdata_d = mode_q;
                hit(avs_address, ccmri_pkg::OFS_CNF_PTR): rdata_d = cnf_q;
                hit(avs_address, ccmri_pkg::OFS_SRC_PTR): rdata_d = src_q;
                hit(avs_address, ccmri_pkg::OFS_DST_PTR): rdata_d = dst_q;
                hit(avs_address, ccmri_pkg::OFS_TMP_PTR): rdata_d = tmp_q;
                hit(avs_address, ccmri_pkg::OFS_EXT_LEN): rdata_d = ext_q;
                hit(avs_address, ccmri_pkg::OFS_ALT_RATE): rdata_d = alt_q;
                hit(avs_address, ccmri_pkg::OFS_HDR_MASK): rdata_d = hdr_q;
                hit(avs_address, ccmri_pkg::OFS_TASK_KS),
                hit(avs_address, ccmri_pkg::OFS_TASK_CIPHER),
                hit(avs_address, ccmri_pkg::OFS_TASK_HALT),
                hit(avs_address, ccmri_pkg::OFS_TASK_SWAP):
                    rdata_d = ccmri_pkg::RESET_ZERO;
                default: resp_d = 2'b11; // unmapped: decode error
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= ccmri_pkg::RESET_ZERO;
            resp_q <= 2'b00;
            ev_q <= 3'h0;
            ien_q <= 3'h0;
            link_q <= 1'b0;
            enable_q <= 2'h0;
            mode_q <= ccmri_pkg::RESET_ZERO;
            cnf_q <= ccmri_pkg::RESET_ZERO;
            src_q <= ccmri_pkg::RESET_ZERO;
            dst_q <= ccmri_pkg::RESET_ZERO;
            tmp_q <= ccmri_pkg::RESET_ZERO;
            ext_q <= ccmri_pkg::RESET_EXT_LEN;
            alt_q <= ccmri_pkg::RESET_ZERO;
            hdr_q <= ccmri_pkg::RESET_HDR_MASK;
            mic_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            ev_q <= ev_d;
            ien_q <= ien_d;
            link_q <= link_d;
            enable_q <= enable_d;
            mode_q <= mode_d;
            cnf_q <= cnf_d;
            src_q <= src_d;
            dst_q <= dst_d;
            tmp_q <= tmp_d;
            ext_q <= ext_d;
            alt_q <= alt_d;
            hdr_q <= hdr_d;
            mic_q <= mic_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    assign irq = |(ev_q & ien_q);

    // operation sequencer driving the memory engine
    ccmri_pkg::ccmri_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] ks_len;
    logic [31:0] addr_q, addr_d;

    assign ks_len = mode_q[ccmri_pkg::MODE_LEN_BIT] ? ext_q[7:0]
                                                     : ccmri_pkg::SHORT_KS_LEN;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        ks_done = 1'b0;
        cipher_done = 1'b0;
        fault = 1'b0;
        unique case (st_q)
            ccmri_pkg::CCMRI_IDLE: begin
                if (go_ks && enable_q == ccmri_pkg::ENABLE_ON) begin
                    // fetch key and nonce from the structure
                    st_d = ccmri_pkg::CCMRI_FETCH;
                    addr_d = cnf_q;
                    cnt_d = ccmri_pkg::CNF_WORDS;
                end else if (go_cipher
                             && enable_q == ccmri_pkg::ENABLE_ON) begin
                    st_d = ccmri_pkg::CCMRI_CIPHER;
                    addr_d = src_q;
                    cnt_d = cipher_len;
                end
            end
            ccmri_pkg::CCMRI_FETCH: begin
                if (mem.ack) begin
                    addr_d = addr_q + 32'h0000_0004;
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        st_d = ccmri_pkg::CCMRI_KEYSTREAM_START;
                        addr_d = tmp_q;
                        cnt_d = ks_len;
                    end
                end
            end
            ccmri_pkg::CCMRI_KEYSTREAM_START: begin
                if (mem.ack) begin
                    addr_d = addr_q + 32'h0000_0004;
                    cnt_d = cnt_q - 8'h01;
                end
                if (cnt_q == 8'h00 || (mem.ack && cnt_q == 8'h01)) begin
                    ks_done = 1'b1;
                    if (link_q) begin
                        st_d = ccmri_pkg::CCMRI_CIPHER;
                        addr_d = src_q;
                        cnt_d = cipher_len;
                    end else begin
                        st_d = ccmri_pkg::CCMRI_DONE;
                    end
                end
            end
            ccmri_pkg::CCMRI_CIPHER: begin
                if (mem.collision) fault = 1'b1;
                if (mem.ack) begin
                    addr_d = addr_q + 32'h0000_0004;
                    cnt_d = cnt_q - 8'h01;
                end
                if (go_halt) begin
                    st_d = ccmri_pkg::CCMRI_DONE;
                end else if (cnt_q == 8'h00 || (mem.ack && cnt_q == 8'h01)) begin
                    cipher_done = 1'b1;
                    st_d = ccmri_pkg::CCMRI_DONE;
                end
            end
            ccmri_pkg::CCMRI_DONE: begin
                // access stopped, wait for engine to drain
                if (!ram_req) st_d = ccmri_pkg::CCMRI_IDLE;
            end
            default: st_d = ccmri_pkg::CCMRI_IDLE;
        endcase
        if (go_halt && st_q == ccmri_pkg::CCMRI_FETCH) begin
            st_d = ccmri_pkg::CCMRI_DONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ccmri_pkg::CCMRI_IDLE;
            cnt_q <= 8'h00;
            addr_q <= ccmri_pkg::RESET_ZERO;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
        end
    end

    // requests only while an operation is active
    assign mem.req = (st_q == ccmri_pkg::CCMRI_FETCH)
        || ((st_q == ccmri_pkg::CCMRI_KEYSTREAM_START
             || st_q == ccmri_pkg::CCMRI_CIPHER) && cnt_q != 8'h00);
    assign mem.addr = addr_q;
    assign mem.wr = st_q == ccmri_pkg::CCMRI_KEYSTREAM_START;
    assign mem.wdata = addr_q ^ hdr_q ^ mode_q;

    ccmri_dma u_dma (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mem(mem),
        .ram_req(ram_req),
        .ram_wr(ram_wr),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata),
        .ram_gnt(ram_gnt),
        .ram_rdata(ram_rdata),
        .ram_busy(ram_busy)
    );
endmodule : ccmri_top

// ### shared/ccmri_mem_if.sv
// interface between the sequencer and the memory access engine
`timescale 1ns/1ps
interface ccmri_mem_if;
    logic req;
    logic [31:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    logic collision;
    modport ctrl (output req, output addr, output wr, output wdata,
        input ack, input rdata, input collision);
    modport eng (input req, input addr, input wr, input wdata,
        output ack, output rdata, output collision);
endinterface : ccmri_mem_if

// ### shared/ccmri_pkg.sv
// constants, offsets and types of the ccm task register interface
package ccmri_pkg;
    localparam logic [31:0] CCMRI_BASE_ADDR = 32'h4000_F000;
    localparam logic [11:0] OFS_TASK_KS = 12'h000;
    localparam logic [11:0] OFS_TASK_CIPHER = 12'h004;
    localparam logic [11:0] OFS_TASK_HALT = 12'h008;
    localparam logic [11:0] OFS_TASK_SWAP = 12'h00c;
    localparam logic [11:0] OFS_EV_KS = 12'h100;
    localparam logic [11:0] OFS_EV_CIPHER = 12'h104;
    localparam logic [11:0] OFS_EV_FAULT = 12'h108;
    localparam logic [11:0] OFS_LINKS = 12'h200;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_MIC = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_MODE = 12'h504;
    localparam logic [11:0] OFS_CNF_PTR = 12'h508;
    localparam logic [11:0] OFS_SRC_PTR = 12'h50c;
    localparam logic [11:0] OFS_DST_PTR = 12'h510;
    localparam logic [11:0] OFS_TMP_PTR = 12'h514;
    localparam logic [11:0] OFS_EXT_LEN = 12'h518;
    localparam logic [11:0] OFS_ALT_RATE = 12'h51c;
    localparam logic [11:0] OFS_HDR_MASK = 12'h520;
    // operating_config fields (own layout)
    localparam int MODE_DIR_BIT = 0;
    localparam int MODE_RATE_LSB = 16;
    localparam int MODE_LEN_BIT = 24;
    localparam logic [1:0] ENABLE_ON = 2'h2;
    // short keystream length in words and default work counts
    localparam logic [7:0] SHORT_KS_LEN = 8'h1b;
    localparam logic [7:0] CNF_WORDS = 8'h0a;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] RESET_EXT_LEN = 32'h0000_00fb;
    localparam logic [31:0] RESET_HDR_MASK = 32'h0000_00e3;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [4:0] {
        CCMRI_IDLE = 5'b00001,
        CCMRI_FETCH = 5'b00010,
        CCMRI_KEYSTREAM_START = 5'b00100,
        CCMRI_CIPHER = 5'b01000,
        CCMRI_DONE = 5'b10000
    } ccmri_state_t;
endpackage : ccmri_pkg

// ### tb/ccmri_ram_model.sv
// data memory model answering the access engine
`timescale 1ns/1ps
module ccmri_ram_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ram_req,
    input wire logic [31:0] ram_addr,
    input wire logic [3:0] lat,
    output logic ram_gnt,
    output logic [31:0] ram_rdata
);
    logic [3:0] cnt_q;
    // grant after lat waiting cycles, data scrambled outside a grant
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            ram_gnt <= 1'b0;
            ram_rdata <= 32'h0000_0000;
        end else begin
            ram_gnt <= 1'b0;
            ram_rdata <= ~ram_rdata;
            if (ram_req && !ram_gnt) begin
                if (cnt_q >= lat) begin
                    ram_gnt <= 1'b1;
                    ram_rdata <= ram_addr ^ 32'h5a5a_5a5a;
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : ccmri_ram_model

// ### tb/ccmri_top_sva.sv
// port checker of the ccm task register interface
`timescale 1ns/1ps
module ccmri_top_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic irq,
    input wire logic ram_req,
    input wire logic ram_wr,
    input wire logic [31:0] ram_addr,
    input wire logic [31:0] ram_wdata,
    input wire logic ram_gnt
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // bus handshake, one wait state
    wait_state_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("no wait state");
    wait_bound_a: assert property ((avs_read || avs_write) |->
        ##[0:1] !avs_waitrequest) else $error("answer late");
    idle_wait_a: assert property (!(avs_read || avs_write) |->
        !avs_waitrequest) else $error("wait while idle");
    // responses by address map
    unmapped_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == 32'h4000_fffc |-> avs_response == 2'b11)
        else $error("unmapped read not flagged");
    mapped_ok_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == 32'h4000_f518 |-> avs_response == 2'b00)
        else $error("mapped read flagged");
    // memory request held until granted
    ram_hold_a: assert property (ram_req && !ram_gnt |=>
        ram_req && $stable(ram_addr) && $stable(ram_wr))
        else $error("memory request dropped");
    wdata_hold_a: assert property (ram_req && ram_wr && !ram_gnt |=>
        $stable(ram_wdata)) else $error("write data moved");
    // events only cleared by software
    irq_sticky_a: assert property ($fell(irq) |->
        $past(avs_write)) else $error("irq fell alone");
    cover property (avs_read && avs_response == 2'b11);
    cover property ($rose(irq));
    cover property (ram_req && ram_gnt && ram_wr);
endmodule : ccmri_top_sva

// ### tb/testbench.sv
// testbench of the ccm task register interface
`timescale 1ns/1ps
module testbench;
    logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic ram_req, ram_wr, ram_gnt, ram_busy;
    logic [31:0] avs_address, avs_writedata, avs_readdata, ram_addr;
    logic [31:0] ram_wdata, ram_rdata, rd, first_addr;
    logic [3:0] lat;
    logic [1:0] avs_response, rsp;
    logic [7:0] cipher_len;
    int fails, n_tests, n_acc, n_tmp, n_short;
    localparam logic [31:0] CNF = 32'h2000_0000;
    localparam logic [31:0] TMP = 32'h2000_1000;
    ccmri_top i_ccmri_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .irq(irq), .ram_req(ram_req), .ram_wr(ram_wr),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_gnt(ram_gnt),
        .ram_rdata(ram_rdata), .ram_busy(ram_busy),
        .cipher_len(cipher_len), .mic_ok(1'b1));
    ccmri_ram_model i_ccmri_ram_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .ram_req(ram_req), .ram_addr(ram_addr), .lat(lat),
        .ram_gnt(ram_gnt), .ram_rdata(ram_rdata));
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // count granted memory accesses
    always @(posedge ref_clk) begin
        if (ram_req === 1'b1 && ram_gnt === 1'b1) begin
            if (n_acc == 0) first_addr = ram_addr;
            n_acc++;
            if (ram_addr >= TMP && ram_addr < TMP + 32'h0000_0400) n_tmp++;
        end
    end
    task automatic check(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic bus(input logic w, input logic [11:0] o,
        input logic [31:0] d);
        avs_address <= ccmri_pkg::CCMRI_BASE_ADDR + {20'h0_0000, o};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic rdc(input string nm, input logic [11:0] o,
        input logic [31:0] e);
        bus(1'b0, o, 32'h0000_0000);
        check(nm, e, rd);
    endtask : rdc
    task automatic waitirq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check("irq", 32'h0000_0001, {31'h0000_0000, irq});
    endtask : waitirq
    task automatic t_regs();
        rdc("ext_len", 12'h518, 32'h0000_00fb);
        rdc("hdr_mask", 12'h520, 32'h0000_00e3);
        rdc("links", 12'h200, 32'h0000_0000);
        bus(1'b0, 12'hffc, 32'h0000_0000);
        check("unmapped", 32'h0000_0003, {30'h0000_0000, rsp});
        bus(1'b1, 12'h508, CNF);
        bus(1'b1, 12'h514, TMP);
        rdc("cnf_ptr", 12'h508, CNF);
        rdc("tmp_ptr", 12'h514, TMP);
        bus(1'b1, 12'h500, 32'h0000_0002);
        bus(1'b1, 12'h304, 32'h0000_0003);
        rdc("irq_en", 12'h304, 32'h0000_0003);
        bus(1'b1, 12'h304, 32'h0000_0000);
        rdc("irq_keep", 12'h304, 32'h0000_0003);
        bus(1'b1, 12'h308, 32'h0000_0002);
        rdc("irq_clr", 12'h308, 32'h0000_0001);
    endtask : t_regs
    task automatic t_ks(input logic ext);
        bus(1'b1, 12'h504, {7'h00, ext, 24'h00_0000});
        n_acc = 0;
        n_tmp = 0;
        bus(1'b1, 12'h000, 32'h0000_0001);
        waitirq();
        check("first_addr", CNF, first_addr);
        check("tmp_used", 32'h0000_0001, {31'h0000_0000, n_tmp > 0});
        repeat (20) @(posedge ref_clk);
        rdc("ks_done", 12'h100, 32'h0000_0001);
        bus(1'b1, 12'h100, 32'h0000_0000);
        check("irq_low", 32'h0000_0000, {31'h0000_0000, irq});
    endtask : t_ks
    task automatic t_link();
        bus(1'b1, 12'h504, 32'h0000_0000);
        bus(1'b1, 12'h200, 32'h0000_0001);
        bus(1'b1, 12'h308, 32'h0000_0001);
        bus(1'b1, 12'h304, 32'h0000_0002);
        cipher_len <= 8'h04;
        bus(1'b1, 12'h000, 32'h0000_0001);
        waitirq();
        rdc("ks_ev", 12'h100, 32'h0000_0001);
        n_acc = 0;
        repeat (50) @(posedge ref_clk);
        check("dma_quiet", 32'h0000_0000, n_acc);
        bus(1'b1, 12'h200, 32'h0000_0000);
        bus(1'b1, 12'h100, 32'h0000_0000);
        bus(1'b1, 12'h104, 32'h0000_0000);
        bus(1'b1, 12'h308, 32'h0000_0002);
    endtask : t_link
    task automatic t_halt_swap();
        lat <= 4'h8;
        cipher_len <= 8'hff;
        bus(1'b1, 12'h504, 32'h0033_0001);
        bus(1'b1, 12'h51c, 32'h0000_005a);
        bus(1'b1, 12'h004, 32'h0000_0001);
        repeat (10) @(posedge ref_clk);
        bus(1'b1, 12'h00c, 32'h0000_0001);
        rdc("rate_swap", 12'h504, 32'h005a_0001);
        bus(1'b1, 12'h008, 32'h0000_0001);
        repeat (300) @(posedge ref_clk);
        rdc("halted", 12'h104, 32'h0000_0000);
        check("req_idle", 32'h0000_0000, {31'h0000_0000, ram_req});
        lat <= 4'h0;
    endtask : t_halt_swap
    task automatic t_fault();
        ram_busy <= 1'b1;
        cipher_len <= 8'h04;
        bus(1'b1, 12'h304, 32'h0000_0004);
        bus(1'b1, 12'h004, 32'h0000_0001);
        waitirq();
        rdc("fault", 12'h108, 32'h0000_0001);
        ram_busy <= 1'b0;
        repeat (300) @(posedge ref_clk);
        rdc("cipher_done", 12'h104, 32'h0000_0001);
        rdc("mic", 12'h400, 32'h0000_0001);
    endtask : t_fault
    task automatic give_verdict();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 32'h0000_0000;
        avs_writedata = 32'h0000_0000;
        ram_busy = 1'b0;
        lat = 4'h0;
        cipher_len = 8'h04;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_ks(1'b0);
        n_short = n_tmp;
        check("ks_short", {24'h00_0000, ccmri_pkg::SHORT_KS_LEN},
            n_short);
        bus(1'b1, 12'h518, 32'h0000_0010);
        t_ks(1'b1);
        check("ks_ext", 32'h0000_0010, n_tmp);
        t_link();
        t_halt_swap();
        t_fault();
        give_verdict();
    end
endmodule : testbench
bind ccmri_top ccmri_top_sva i_ccmri_top_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .irq(irq), .ram_req(ram_req),
    .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_gnt(ram_gnt));
